// ===== logic/tacf_pkg.sv
// constants and types for the type a card activation state machine
package tacf_pkg;

   // ----------------------------------------------------------------
   // frame delay timing
   // ----------------------------------------------------------------
   // figures are in carrier periods; the link clock runs at the carrier
   localparam int FDT_LAST_ZERO_FC = 1172;
   localparam int FDT_LAST_ONE_FC = 1236;
   localparam int LCLK_PER_FC = 1;
   localparam int FDT_LAST_ZERO_CYC = FDT_LAST_ZERO_FC * LCLK_PER_FC;
   localparam int FDT_LAST_ONE_CYC = FDT_LAST_ONE_FC * LCLK_PER_FC;
   localparam int FDT_W = 11;
   // edges that the load, done flag, due flag and start flop add beyond the count
   localparam int FDT_PIPE_CYC = 4;

   // ----------------------------------------------------------------
   // command codes and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_REQA = 8'h26;
   localparam logic [7:0] CODE_WUPA = 8'h52;
   localparam logic [7:0] CODE_HLTA = 8'h50;
   localparam logic [7:0] CODE_SEL1 = 8'h93;
   localparam logic [7:0] CODE_SEL2 = 8'h95;
   localparam logic [7:0] CODE_SEL3 = 8'h97;
   localparam logic [7:0] NVB_FULL = 8'h70;
   localparam logic [7:0] CODE_RATS = 8'he0;
   localparam logic [7:0] RATS_PARAM_00 = 8'h00;
   localparam int UID_W = 32;
   localparam int NBITS_W = 6;
   localparam int LEVEL_W = 2;
   localparam logic [LEVEL_W-1:0] LEVEL_NONE = 2'h0;
   localparam logic [LEVEL_W-1:0] LEVEL_FIRST = 2'h1;
   localparam logic [LEVEL_W-1:0] LEVEL_STEP = 2'h1;
   localparam logic [NBITS_W-1:0] NBITS_FULL = 6'h20;

   // ----------------------------------------------------------------
   // enumerations and carriers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {CS_OFF, CS_IDLE, CS_READY, CS_ACTIVE, CS_PROTO, CS_HALT}
      tacf_state_type;
   typedef enum logic [2:0] {CK_REQA, CK_WUPA, CK_HLTA, CK_AC, CK_SEL, CK_RATS, CK_OTHER}
      tacf_cmd_type;
   typedef enum logic [2:0] {RK_NONE, RK_ATQA, RK_UID, RK_SAK, RK_ATS} tacf_resp_kind_type;

   // decoded reader frame, handed over by the bit-level receiver
   typedef struct packed {
      logic [7:0] cmd_byte;
      logic [7:0] param_byte;
      logic [UID_W-1:0] uid;
      logic [7:0] bcc;
      logic [NBITS_W-1:0] nbits;
      logic is_short;
      logic crc_ok;
      logic last_bit;
   } tacf_frame_type;

   // answer order for the bit-level transmitter
   typedef struct packed {
      tacf_resp_kind_type kind;
      logic cascade;
      logic [LEVEL_W-1:0] level;
      logic [NBITS_W-1:0] skip;
   } tacf_resp_type;

endpackage

// ===== logic/tacf_sync3.sv
// three flip-flop level synchroniser with agreement filter
module tacf_sync3
   import tacf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } tacf_sync_state_type;

   tacf_sync_state_type st;
   tacf_sync_state_type next_st;

   // output follows only once second and third stage agree
   always_comb
   begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3)
      begin
         next_st.q = st.s3;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign q = st.q;

endmodule

// ===== logic/tacf_fdt_timer.sv
// frame delay timer on the link clock
module tacf_fdt_timer
   import tacf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic last_bit,
   output logic done
);

   typedef struct packed {
      logic busy;
      logic [FDT_W-1:0] cnt;
      logic done;
   } tacf_timer_state_type;

   tacf_timer_state_type st;
   tacf_timer_state_type next_st;

   // delay depends on the last bit the reader sent
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      if (start)
      begin
         next_st.busy = 1'b1;
         next_st.cnt = last_bit ? FDT_W'(FDT_LAST_ONE_CYC - FDT_PIPE_CYC) :
                                  FDT_W'(FDT_LAST_ZERO_CYC - FDT_PIPE_CYC);
      end
      else if (st.busy)
      begin
         if (st.cnt == '0)
         begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
         else
         begin
            next_st.cnt = st.cnt - FDT_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign done = st.done;

endmodule

// ===== logic/tacf_top.sv
// type a card activation state machine with link-side answer timing
module tacf_top
   import tacf_pkg::*;
#(
   parameter int CASCADE_LEVEL_COUNT = 1,
   // uid words per cascade level; values are arbitrary
   parameter logic [UID_W-1:0] UID_LEVEL1 = 32'h0a1b2c3d,
   parameter logic [UID_W-1:0] UID_LEVEL2 = 32'h4e5f6071,
   parameter logic [UID_W-1:0] UID_LEVEL3 = 32'h8293a4b5
)
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic LCLK,
   input wire logic RF_ON,
   input wire logic FRAME_DONE,
   input wire tacf_frame_type FRAME,
   output logic RESP_START,
   output tacf_resp_type RESP,
   output tacf_state_type CARD_STATE,
   output logic CARD_STARRED,
   output logic [LEVEL_W-1:0] CARD_LEVEL
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (CASCADE_LEVEL_COUNT < 1 || CASCADE_LEVEL_COUNT > 3)
   begin : g_bad_levels
      $error("cascade level count must be 1, 2 or 3");
   end

   localparam logic [LEVEL_W-1:0] LAST_LEVEL = LEVEL_W'(CASCADE_LEVEL_COUNT);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // cascade level named by a select or anticollision code, none if other
   function automatic logic [LEVEL_W-1:0] level_of(input logic [7:0] code);
      logic [LEVEL_W-1:0] lv;
      lv = LEVEL_NONE;
      if (code == CODE_SEL1)
      begin
         lv = 2'h1;
      end
      else if (code == CODE_SEL2)
      begin
         lv = 2'h2;
      end
      else if (code == CODE_SEL3)
      begin
         lv = 2'h3;
      end
      return lv;
   endfunction

   // sort a frame into the command classes the state machine acts on
   function automatic tacf_cmd_type classify(input tacf_frame_type f);
      tacf_cmd_type c;
      c = CK_OTHER;
      if (f.is_short)
      begin
         if (f.cmd_byte == CODE_REQA)
         begin
            c = CK_REQA;
         end
         else if (f.cmd_byte == CODE_WUPA)
         begin
            c = CK_WUPA;
         end
      end
      else if (level_of(f.cmd_byte) != LEVEL_NONE)
      begin
         // a full select with broken crc stays other, so it falls back
         if (f.param_byte != NVB_FULL)
         begin
            c = CK_AC;
         end
         else if (f.crc_ok)
         begin
            c = CK_SEL;
         end
      end
      else if (f.crc_ok && f.cmd_byte == CODE_HLTA)
      begin
         c = CK_HLTA;
      end
      else if (f.crc_ok && f.cmd_byte == CODE_RATS)
      begin
         c = CK_RATS;
      end
      return c;
   endfunction

   // uid word of the given cascade level
   function automatic logic [UID_W-1:0] uid_of(input logic [LEVEL_W-1:0] lv);
      logic [UID_W-1:0] w;
      w = UID_LEVEL1;
      if (lv == 2'h2)
      begin
         w = UID_LEVEL2;
      end
      else if (lv == 2'h3)
      begin
         w = UID_LEVEL3;
      end
      return w;
   endfunction

   // check byte over the four uid bytes
   function automatic logic [7:0] bcc_of(input logic [UID_W-1:0] w);
      return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
   endfunction

   // ----------------------------------------------------------------
   // state of both domains
   // ----------------------------------------------------------------
   typedef struct packed {
      tacf_frame_type held;
      logic frm_tog;
      logic ans_seen;
      logic waiting;
      logic fdt_due;
      logic ans_ready;
      logic start;
      tacf_resp_type resp;
   } tacf_link_state_type;

   typedef struct packed {
      tacf_state_type state;
      logic star;
      logic [LEVEL_W-1:0] level;
      logic frm_seen;
      logic ans_tog;
      tacf_resp_type ans;
   } tacf_core_state_type;

   tacf_link_state_type lk;
   tacf_link_state_type next_lk;
   tacf_core_state_type mc;
   tacf_core_state_type next_mc;

   logic lrst;
   logic rf_on;
   logic frm_sync;
   logic ans_sync;
   logic fdt_done;

   // ----------------------------------------------------------------
   // crossings
   // ----------------------------------------------------------------
   // reset reaches the link side late; the link clock may be stopped
   tacf_sync3 u_lrst
   (
      .clk(LCLK),
      .rst(1'b0),
      .d(RST),
      .q(lrst)
   );

   // field presence pin
   tacf_sync3 u_rf
   (
      .clk(MCLK),
      .rst(RST),
      .d(RF_ON),
      .q(rf_on)
   );

   // frame event toggle into the core domain
   tacf_sync3 u_frm
   (
      .clk(MCLK),
      .rst(RST),
      .d(lk.frm_tog),
      .q(frm_sync)
   );

   // answer event toggle back to the link domain
   tacf_sync3 u_ans
   (
      .clk(LCLK),
      .rst(lrst),
      .d(mc.ans_tog),
      .q(ans_sync)
   );

   // frame delay counted from the end of the reader frame
   tacf_fdt_timer u_fdt
   (
      .clk(LCLK),
      .rst(lrst),
      .start(FRAME_DONE),
      .last_bit(FRAME.last_bit),
      .done(fdt_done)
   );

   // ----------------------------------------------------------------
   // link domain
   // ----------------------------------------------------------------
   // hold the frame, then release the answer once both the delay has run
   // out and the core has decided; held stays still until the next frame
   always_comb
   begin
      next_lk = lk;
      next_lk.start = 1'b0;
      if (FRAME_DONE)
      begin
         next_lk.held = FRAME;
         next_lk.frm_tog = ~lk.frm_tog;
         next_lk.waiting = 1'b1;
         next_lk.fdt_due = 1'b0;
         next_lk.ans_ready = 1'b0;
      end
      else
      begin
         if (fdt_done)
         begin
            next_lk.fdt_due = 1'b1;
         end
         if (ans_sync != lk.ans_seen)
         begin
            next_lk.ans_ready = 1'b1;
         end
         // a late decision still sends at once rather than never
         if (lk.waiting && lk.fdt_due && lk.ans_ready)
         begin
            next_lk.waiting = 1'b0;
            next_lk.resp = mc.ans; // stable: written on the same edge as its toggle, seen here only later
            next_lk.start = (mc.ans.kind != RK_NONE);
         end
      end
      next_lk.ans_seen = ans_sync;
   end

   // link register
   always_ff @(posedge LCLK)
   begin
      if (lrst)
      begin
         lk <= '0;
      end
      else
      begin
         lk <= next_lk;
      end
   end

   // ----------------------------------------------------------------
   // core state machine
   // ----------------------------------------------------------------
   tacf_cmd_type cmd;
   logic [LEVEL_W-1:0] cmd_level;
   logic [UID_W-1:0] prefix_mask;
   logic prefix_ok;
   logic select_ok;
   tacf_state_type fall_state;

   // frame decode against the current cascade level
   always_comb
   begin
      cmd = classify(lk.held);
      cmd_level = level_of(lk.held.cmd_byte);
      if (lk.held.nbits >= NBITS_FULL)
      begin
         prefix_mask = '1;
      end
      else
      begin
         prefix_mask = (UID_W'(1) << lk.held.nbits) - UID_W'(1);
      end
      prefix_ok = (cmd_level == mc.level) &&
                  (((lk.held.uid ^ uid_of(mc.level)) & prefix_mask) == '0);
      select_ok = (cmd_level == mc.level) && (lk.held.uid == uid_of(mc.level)) &&
                  (lk.held.bcc == bcc_of(uid_of(mc.level)));
      fall_state = mc.star ? CS_HALT : CS_IDLE;
   end

   // one decision per frame; every frame seen with the field on and the card out of off gets an answer order, maybe none
   always_comb
   begin
      next_mc = mc;
      if (!rf_on)
      begin
         // losing the field wipes all activation progress
         next_mc.state = CS_OFF;
         next_mc.star = 1'b0;
         next_mc.level = LEVEL_FIRST;
         next_mc.frm_seen = frm_sync;
      end
      else if (mc.state == CS_OFF)
      begin
         next_mc.state = CS_IDLE;
         next_mc.frm_seen = frm_sync;
      end
      else if (frm_sync != mc.frm_seen)
      begin
         next_mc.frm_seen = frm_sync;
         next_mc.ans_tog = ~mc.ans_tog;
         next_mc.ans = '0;
         next_mc.ans.level = mc.level;
         case (mc.state)
            CS_IDLE:
            begin
               // anything but reqa/wupa is ignored here
               if (cmd == CK_REQA || cmd == CK_WUPA)
               begin
                  next_mc.ans.kind = RK_ATQA;
                  next_mc.state = CS_READY;
                  next_mc.star = 1'b0;
                  next_mc.level = LEVEL_FIRST;
               end
            end
            CS_HALT:
            begin
               if (cmd == CK_WUPA)
               begin
                  next_mc.ans.kind = RK_ATQA;
                  next_mc.state = CS_READY;
                  next_mc.star = 1'b1;
                  next_mc.level = LEVEL_FIRST;
               end
            end
            CS_READY:
            begin
               if (cmd == CK_AC && prefix_ok)
               begin
                  next_mc.ans.kind = RK_UID;
                  next_mc.ans.skip = lk.held.nbits;
               end
               else if (cmd == CK_SEL && select_ok)
               begin
                  next_mc.ans.kind = RK_SAK;
                  if (mc.level < LAST_LEVEL)
                  begin
                     next_mc.ans.cascade = 1'b1;
                     next_mc.level = mc.level + LEVEL_STEP;
                  end
                  else
                  begin
                     next_mc.state = CS_ACTIVE;
                  end
               end
               else
               begin
                  // wrong uid, bad crc or foreign command: mute
                  next_mc.state = fall_state;
                  next_mc.level = LEVEL_FIRST;
               end
            end
            CS_ACTIVE:
            begin
               if (cmd == CK_RATS && lk.held.param_byte == RATS_PARAM_00)
               begin
                  next_mc.ans.kind = RK_ATS;
                  next_mc.state = CS_PROTO;
               end
               else if (cmd == CK_HLTA)
               begin
                  next_mc.state = CS_HALT;
                  next_mc.level = LEVEL_FIRST;
               end
               else
               begin
                  next_mc.state = fall_state;
                  next_mc.level = LEVEL_FIRST;
               end
            end
            CS_PROTO:
            begin
               // block protocol is handled elsewhere; stay put and stay silent
               next_mc.state = CS_PROTO;
            end
            default:
            begin
               next_mc.state = CS_OFF;
            end
         endcase
      end
   end

   // core register
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         mc <= '{state: CS_OFF, star: 1'b0, level: LEVEL_FIRST, frm_seen: 1'b0,
                 ans_tog: 1'b0, ans: '0};
      end
      else
      begin
         mc <= next_mc;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign RESP_START = lk.start;
   assign RESP = lk.resp;
   assign CARD_STATE = mc.state;
   assign CARD_STARRED = mc.star;
   assign CARD_LEVEL = mc.level;

endmodule

// ===== verif/tacf_checker.sv
// assertion checker for the card activation state machine, bound to its top
module tacf_checker
   import tacf_pkg::*;
#(
   parameter int CASCADE_LEVEL_COUNT = 1
)
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic LCLK,
   input wire logic RF_ON,
   input wire logic FRAME_DONE,
   input wire tacf_frame_type FRAME,
   input wire logic RESP_START,
   input wire tacf_resp_type RESP,
   input wire tacf_state_type CARD_STATE,
   input wire logic CARD_STARRED,
   input wire logic [LEVEL_W-1:0] CARD_LEVEL
);
   // ----------------------------------------------------------------
   // link side frame delay counter
   // ----------------------------------------------------------------
   // saturates, so a long mute gap never wraps into a false match
   logic [11:0] fdt_cnt;
   logic [11:0] fdt_exp;
   always_ff @(posedge LCLK)
   begin
      if (RST)
         fdt_cnt <= 12'hfff;
      else if (FRAME_DONE)
      begin
         fdt_cnt <= 12'h001;
         fdt_exp <= FRAME.last_bit ? 12'(FDT_LAST_ONE_CYC) : 12'(FDT_LAST_ZERO_CYC);
      end
      else if (fdt_cnt != 12'hfff)
         fdt_cnt <= fdt_cnt + 12'h001;
   end

   // ----------------------------------------------------------------
   // sequences and assertions
   // ----------------------------------------------------------------
   sequence s_leave(tacf_state_type s);
      CARD_STATE == s ##1 (CARD_STATE != s && CARD_STATE != CS_OFF);
   endsequence

   a_resp_on_time:
      assert property (@(posedge LCLK) disable iff (RST) RESP_START |-> fdt_cnt == fdt_exp)
      else $error("answer start not at the frame delay");
   a_resp_pulse:
      assert property (@(posedge LCLK) disable iff (RST) RESP_START |=> !RESP_START)
      else $error("answer start longer than one cycle");
   a_reset_off:
      assert property (@(posedge MCLK) RST |=> CARD_STATE == CS_OFF && !CARD_STARRED
         && CARD_LEVEL == LEVEL_FIRST)
      else $error("reset did not clear the card");
   a_field_drop:
      assert property (@(posedge MCLK) disable iff (RST)
         $fell(RF_ON) |-> ##[1:5] CARD_STATE == CS_OFF)
      else $error("field loss not seen in time");
   a_power_idle:
      assert property (@(posedge MCLK) disable iff (RST)
         CARD_STATE == CS_OFF ##1 CARD_STATE != CS_OFF |-> CARD_STATE == CS_IDLE)
      else $error("power-up did not land in idle");
   a_idle_exit:
      assert property (@(posedge MCLK) disable iff (RST) s_leave(CS_IDLE) |->
         CARD_STATE == CS_READY && !CARD_STARRED && CARD_LEVEL == LEVEL_FIRST)
      else $error("idle left to a wrong state");
   a_halt_wake:
      assert property (@(posedge MCLK) disable iff (RST) s_leave(CS_HALT) |->
         CARD_STATE == CS_READY && CARD_STARRED && CARD_LEVEL == LEVEL_FIRST)
      else $error("halt left to a wrong state");
   a_proto_hold:
      assert property (@(posedge MCLK) disable iff (RST)
         CARD_STATE == CS_PROTO |=> CARD_STATE inside {CS_PROTO, CS_OFF})
      else $error("protocol state left without field loss");
   a_level_step:
      assert property (@(posedge MCLK) disable iff (RST)
         CARD_STATE == CS_READY ##1 (CARD_STATE == CS_READY && $changed(CARD_LEVEL))
         |-> CARD_LEVEL == $past(CARD_LEVEL) + LEVEL_STEP)
      else $error("cascade level skipped");
   a_level_range:
      assert property (@(posedge MCLK) disable iff (RST)
         CARD_LEVEL >= LEVEL_FIRST && CARD_LEVEL <= LEVEL_W'(CASCADE_LEVEL_COUNT))
      else $error("cascade level out of range");
   a_starred_fall:
      assert property (@(posedge MCLK) disable iff (RST)
         (CARD_STATE == CS_READY && CARD_STARRED) ##1 CARD_STATE != CS_READY
         |-> CARD_STATE != CS_IDLE)
      else $error("starred state fell back to idle");
endmodule

bind tacf_top tacf_checker #(.CASCADE_LEVEL_COUNT(CASCADE_LEVEL_COUNT)) u_tacf_checker (
   .MCLK(MCLK), .RST(RST), .LCLK(LCLK), .RF_ON(RF_ON), .FRAME_DONE(FRAME_DONE),
   .FRAME(FRAME), .RESP_START(RESP_START), .RESP(RESP), .CARD_STATE(CARD_STATE),
   .CARD_STARRED(CARD_STARRED), .CARD_LEVEL(CARD_LEVEL));

// ===== verif/tacf_reader.sv
// reader model: hands decoded frames to the card and times its answer
module tacf_reader
   import tacf_pkg::*;
(
   input wire logic LCLK,
   input wire logic RESP_START,
   input wire tacf_resp_type RESP,
   output logic FRAME_DONE,
   output tacf_frame_type FRAME
);
   timeunit 1ns;
   timeprecision 100ps;
   logic got;
   int dly;
   tacf_resp_type ans;

   initial
   begin
      FRAME_DONE = 1'b0;
      FRAME = '0;
   end

   // ----------------------------------------------------------------
   // one frame, then the full spacing before the next may go
   // ----------------------------------------------------------------
   // waiting 1300 cycles every time keeps the minimum frame spacing
   task automatic send(input tacf_frame_type f);
      @(posedge LCLK);
      #1;
      FRAME_DONE = 1'b1;
      FRAME = f;
      @(posedge LCLK);
      #1;
      FRAME_DONE = 1'b0;
      FRAME = ~f; // released: never leave the old frame standing
      got = 1'b0;
      dly = 0;
      for (int k = 1; k <= 1300; k++)
      begin
         @(posedge LCLK);
         if (RESP_START === 1'b1 && !got)
         begin
            got = 1'b1;
            dly = k;
            ans = RESP;
         end
      end
   endtask
endmodule

// ===== verif/tacf_top_tb.sv
// self-checking bench for the card activation state machine
module tacf_top_tb
   import tacf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LEVELS = 2;
   localparam logic [UID_W-1:0] UID1 = 32'h0a1b2c3d;
   localparam logic [UID_W-1:0] UID2 = 32'h4e5f6071;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst = 1'b1;
   logic rf_on = 1'b0;
   logic frame_done;
   tacf_frame_type frame;
   logic resp_start;
   tacf_resp_type resp;
   tacf_state_type card_state;
   logic card_starred;
   logic [LEVEL_W-1:0] card_level;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;

   // frame builder; check byte made from the uid bytes
   function automatic tacf_frame_type fr(input logic [7:0] c, input logic [7:0] p,
         input logic [31:0] u, input logic [5:0] n, input logic sh, input logic ok,
         input logic lb);
      return '{c, p, u, u[31:24] ^ u[23:16] ^ u[15:8] ^ u[7:0], n, sh, ok, lb};
   endfunction

   localparam tacf_frame_type REQ = fr(CODE_REQA, 8'h00, 32'h0, 6'h00, 1'b1, 1'b1, 1'b0);
   localparam tacf_frame_type WUP = fr(CODE_WUPA, 8'h00, 32'h0, 6'h00, 1'b1, 1'b1, 1'b1);
   localparam tacf_frame_type HLT = fr(CODE_HLTA, 8'h00, 32'h0, 6'h00, 1'b0, 1'b1, 1'b0);
   localparam tacf_frame_type RAT = fr(CODE_RATS, RATS_PARAM_00, 32'h0, 6'h00, 1'b0, 1'b1, 1'b0);
   localparam tacf_frame_type STD = fr(CODE_REQA, 8'h00, 32'h0, 6'h00, 1'b0, 1'b1, 1'b0);
   localparam tacf_frame_type SL1 = fr(CODE_SEL1, NVB_FULL, UID1, NBITS_FULL, 1'b0, 1'b1, 1'b1);
   localparam tacf_frame_type SL2 = fr(CODE_SEL2, NVB_FULL, UID2, NBITS_FULL, 1'b0, 1'b1, 1'b0);

   // ----------------------------------------------------------------
   // clocks, design, reader and hang guard
   // ----------------------------------------------------------------
   always #10 mclk = ~mclk;
   // link edges at 3 + 6n never meet core edges at 10 + 20m
   always #3 lclk = ~lclk;

   tacf_top #(.CASCADE_LEVEL_COUNT(LEVELS), .UID_LEVEL1(UID1), .UID_LEVEL2(UID2)) u_tacf_top (
      .MCLK(mclk), .RST(rst), .LCLK(lclk), .RF_ON(rf_on), .FRAME_DONE(frame_done),
      .FRAME(frame), .RESP_START(resp_start), .RESP(resp), .CARD_STATE(card_state),
      .CARD_STARRED(card_starred), .CARD_LEVEL(card_level));

   tacf_reader u_reader (.LCLK(lclk), .RESP_START(resp_start), .RESP(resp),
      .FRAME_DONE(frame_done), .FRAME(frame));

   // ceiling well above the roughly 14500 core cycles the frames take
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // compares and common steps
   // ----------------------------------------------------------------
   task automatic chk_bits(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // star flag only means something in ready and active
   task automatic chk_state(input tacf_state_type s, input logic st);
      checks_done++;
      if (card_state !== s || (s inside {CS_READY, CS_ACTIVE} && card_starred !== st))
      begin
         err_count++;
         $display("[FAIL] %0t card state %0d want %0d", $time, card_state, s);
      end
   endtask

   // aux is the cascade bit for a select answer, the skip count for a uid answer
   task automatic cmd(input tacf_frame_type f, input tacf_resp_kind_type k,
         input logic [11:0] aux, input tacf_state_type s, input logic st);
      u_reader.send(f);
      chk_bits(12'(u_reader.got), 12'(k != RK_NONE));
      if (k != RK_NONE)
      begin
         chk_bits(12'(u_reader.dly), 12'(f.last_bit ? FDT_LAST_ONE_CYC : FDT_LAST_ZERO_CYC));
         chk_bits(12'(u_reader.ans.kind), 12'(k));
         if (k == RK_SAK)
            chk_bits(12'(u_reader.ans.cascade), aux);
         if (k == RK_UID)
            chk_bits(12'(u_reader.ans.skip), aux);
      end
      chk_state(s, st);
   endtask

   task automatic field(input logic on);
      @(posedge mclk);
      #1;
      rf_on = on;
      repeat (12) @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_idle;
      field(1'b1);
      chk_state(CS_IDLE, 1'b0);
      cmd(HLT, RK_NONE, 12'h0, CS_IDLE, 1'b0);
      cmd(SL1, RK_NONE, 12'h0, CS_IDLE, 1'b0);
      cmd(RAT, RK_NONE, 12'h0, CS_IDLE, 1'b0);
      cmd(STD, RK_NONE, 12'h0, CS_IDLE, 1'b0);
      cmd(REQ, RK_ATQA, 12'h0, CS_READY, 1'b0);
   endtask

   task automatic t_ready;
      cmd(fr(CODE_SEL1, 8'h34, UID1, 6'h0c, 0, 1, 1), RK_UID, 12'h00c, CS_READY, 0);
      cmd(fr(CODE_SEL1, 8'h40, UID1, 6'h10, 0, 1, 0), RK_UID, 12'h010, CS_READY, 0);
      cmd(fr(CODE_SEL1, NVB_FULL, UID1, NBITS_FULL, 0, 0, 1), RK_NONE, 0, CS_IDLE, 0);
      cmd(WUP, RK_ATQA, 12'h0, CS_READY, 1'b0);
      cmd(fr(CODE_SEL1, 8'h40, ~UID1, 6'h10, 0, 1, 1), RK_NONE, 0, CS_IDLE, 0);
      cmd(REQ, RK_ATQA, 12'h0, CS_READY, 1'b0);
      cmd(fr(CODE_SEL1, NVB_FULL, ~UID1, NBITS_FULL, 0, 1, 1), RK_NONE, 0, CS_IDLE, 0);
      cmd(REQ, RK_ATQA, 12'h0, CS_READY, 1'b0);
      cmd(HLT, RK_NONE, 12'h0, CS_IDLE, 1'b0);
      cmd(REQ, RK_ATQA, 12'h0, CS_READY, 1'b0);
      cmd(WUP, RK_NONE, 12'h0, CS_IDLE, 1'b0);
   endtask

   task automatic t_activate(input logic star);
      cmd(star ? WUP : REQ, RK_ATQA, 12'h0, CS_READY, star);
      cmd(SL1, RK_SAK, 12'h1, CS_READY, star);
      chk_bits(12'(card_level), 12'h002);
      cmd(SL2, RK_SAK, 12'h0, CS_ACTIVE, star);
   endtask

   task automatic t_proto;
      t_activate(1'b0);
      cmd(RAT, RK_ATS, 12'h0, CS_PROTO, 1'b0);
      cmd(REQ, RK_NONE, 12'h0, CS_PROTO, 1'b0);
      field(1'b0);
      chk_state(CS_OFF, 1'b0);
      field(1'b1);
      chk_state(CS_IDLE, 1'b0);
   endtask

   task automatic t_halt;
      t_activate(1'b0);
      cmd(HLT, RK_NONE, 12'h0, CS_HALT, 1'b0);
      cmd(REQ, RK_NONE, 12'h0, CS_HALT, 1'b0);
      t_activate(1'b1);
      cmd(REQ, RK_NONE, 12'h0, CS_HALT, 1'b0);
      cmd(REQ, RK_NONE, 12'h0, CS_HALT, 1'b0);
      cmd(WUP, RK_ATQA, 12'h0, CS_READY, 1'b1);
      cmd(REQ, RK_NONE, 12'h0, CS_HALT, 1'b0);
   endtask

   task automatic t_other;
      field(1'b0);
      field(1'b1);
      t_activate(1'b0);
      cmd(WUP, RK_NONE, 12'h0, CS_IDLE, 1'b0);
   endtask

   task automatic end_sim;
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // main sequence: reset held 16 cycles, field raised by the first scenario
   initial
   begin
      repeat (16) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (8) @(posedge mclk);
      t_idle();
      t_ready();
      t_proto();
      t_halt();
      t_other();
      end_sim();
   end
endmodule
